// file: bench/break_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
module break_bus_partner (
  // Clock
  input  wire logic       clk,
  // Cycle seen by the break unit
  output var  logic       cpu_cyc,
  output var  logic       dma_cyc,
  output var  logic       ext_cyc,
  output var  logic       fetch_cyc,
  output var  logic       chan_a_addr_hit,
  output var  logic       chan_b_addr_hit,
  output var  logic       chan_b_data_hit,
  // Break request
  input  wire logic       break_req,
  input  wire logic       break_after,
  input  wire logic       break_chan_b,
  // Seen by the interrupt side
  output var  logic [7:0] req_count,
  output var  logic       last_after,
  output var  logic       last_chan_b
);
  initial begin
    {cpu_cyc, dma_cyc, ext_cyc, fetch_cyc} = 4'h0;
    {chan_a_addr_hit, chan_b_addr_hit, chan_b_data_hit} = 3'h0;
    req_count = 8'h00;
    last_after = 1'b0;
    last_chan_b = 1'b0;
  end
  // Qualifiers are only valid with the one-cycle request
  always @(posedge clk) begin
    if (break_req) begin
      req_count <= req_count + 8'h01;
      last_after <= break_after;
      last_chan_b <= break_chan_b;
    end
  end
  // One cycle kind per clock; hit lines flip when idle
  task cyc(input [2:0] k, input [2:0] h);
    begin
      @(posedge clk);
      {ext_cyc, dma_cyc, cpu_cyc} <= k;
      fetch_cyc <= k[0];
      {chan_a_addr_hit, chan_b_addr_hit, chan_b_data_hit} <= h;
      @(posedge clk);
      {ext_cyc, dma_cyc, cpu_cyc} <= 3'h0;
      fetch_cyc <= 1'b0;
      {chan_a_addr_hit, chan_b_addr_hit, chan_b_data_hit} <= ~h;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // break_bus_partner
`default_nettype wire

// file: bench/break_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module break_control_props (
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic manual_rst,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Observed cycle
  input wire logic cpu_cyc,
  input wire logic dma_cyc,
  input wire logic ext_cyc,
  input wire logic bus_cfg_total,
  input wire logic chan_a_addr_hit,
  input wire logic chan_b_addr_hit,
  input wire logic chan_b_data_hit,
  // Break side
  input wire logic break_req,
  input wire logic break_after,
  input wire logic break_chan_b,
  input wire logic legacy_mode_select,
  input wire logic chained_channel_select
);
  default clocking @(posedge clk); endclocking
  // Manual reset clears break outputs, so it masks checks too
  default disable iff (sys_rst || manual_rst);
  a_a_cpu_break: assert property (
    cpu_cyc && chan_a_addr_hit && !chan_b_addr_hit && !chained_channel_select
    |=> break_req && !break_chan_b) else $error("channel A break missing");
  a_b_dma_break: assert property (
    dma_cyc && chan_b_addr_hit && chan_b_data_hit && !chan_a_addr_hit &&
    !chained_channel_select |=> break_req && break_chan_b)
    else $error("channel B break missing");
  a_ext_gated: assert property (
    ext_cyc && !bus_cfg_total |=> !break_req) else $error("ext break");
  a_no_hit_quiet: assert property (
    !chan_a_addr_hit && !chan_b_addr_hit |=> !break_req)
    else $error("break without hit");
  a_chain_silent: assert property (
    chained_channel_select && !chan_b_addr_hit |=> !break_req)
    else $error("chained break without B");
  a_legacy_before: assert property (
    break_req && !$past(legacy_mode_select) |-> !break_after)
    else $error("legacy after break");
  a_aw_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("aw taken during resp");
  a_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("ar taken during resp");
  c_chan_b: cover property (break_req && break_chan_b);
  c_after: cover property (break_req && break_after);
  c_chain: cover property (chained_channel_select && break_req);
endmodule // break_control_props
bind break_control break_control_props i_props (.clk, .sys_rst, .manual_rst,
  .s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .cpu_cyc,
  .dma_cyc, .ext_cyc, .bus_cfg_total, .chan_a_addr_hit, .chan_b_addr_hit,
  .chan_b_data_hit, .break_req, .break_after, .break_chan_b,
  .legacy_mode_select, .chained_channel_select);
`default_nettype wire

// file: bench/break_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "break_ctrl_defs.vh"
module break_control_tb_top;
  logic        clk, sys_rst, manual_rst, bus_cfg_total;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rr, br;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
  wire         s_axi_arready, s_axi_rvalid, last_after, last_chan_b;
  wire         break_req, break_after, break_chan_b, fetch_cyc;
  wire         legacy_mode_select, chained_channel_select;
  wire         cpu_cyc, dma_cyc, ext_cyc;
  wire         chan_a_addr_hit, chan_b_addr_hit, chan_b_data_hit;
  wire  [7:0]  req_count;
  integer      bad_count, tests_run;
  break_control i_dut (.clk, .sys_rst, .manual_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_cyc,
    .dma_cyc, .ext_cyc, .fetch_cyc, .bus_cfg_total, .chan_a_addr_hit,
    .chan_b_addr_hit, .chan_b_data_hit, .break_req, .break_after,
    .break_chan_b, .irq, .legacy_mode_select, .chained_channel_select);
  break_bus_partner i_p (.clk, .cpu_cyc, .dma_cyc, .ext_cyc, .fetch_cyc,
    .chan_a_addr_hit, .chan_b_addr_hit, .chan_b_data_hit, .break_req,
    .break_after, .break_chan_b, .req_count, .last_after, .last_chan_b);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task end_of_test;
    begin
      if (bad_count == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task hang;
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      end_of_test;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    integer n;
    logic   ta, tw, tb;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      tb = 1'b0;
      for (n = 0; n < 64 && !tb; n = n + 1) begin
        @(negedge clk);
        ta = s_axi_awvalid & s_axi_awready;
        tw = s_axi_wvalid & s_axi_wready;
        tb = s_axi_bvalid;
        br = s_axi_bresp;
        @(posedge clk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (tb) s_axi_bready <= 1'b0;
      end
      if (!tb) hang;
    end
  endtask
  task rd(input [11:0] a);
    integer n;
    logic   ta, tr;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      tr = 1'b0;
      for (n = 0; n < 64 && !tr; n = n + 1) begin
        @(negedge clk);
        ta = s_axi_arvalid & s_axi_arready;
        tr = s_axi_rvalid;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge clk);
        if (ta) s_axi_arvalid <= 1'b0;
        if (tr) s_axi_rready <= 1'b0;
      end
      if (!tr) hang;
    end
  endtask
  // Flags are written as zero first, so every try starts with clear flags; chain arming carries over
  task try(input [15:0] cfg, input [2:0] k, input [2:0] h,
           input [15:0] ef, input [7:0] er, input [1:0] eab);
    logic [7:0] r0;
    begin
      wr(`OFF_BREAK_CONTROL, {16'h0000, cfg});
      r0 = req_count;
      i_p.cyc(k, h);
      rd(`OFF_BREAK_CONTROL);
      chk(rv, {16'h0000, cfg | ef});
      chk({24'h00_0000, req_count - r0}, {24'h00_0000, er});
      if (er != 8'h00) chk({30'h0, last_after, last_chan_b}, {30'h0, eab});
    end
  endtask
  task t_regs;
    begin
      rd(`OFF_BREAK_CONTROL);
      chk(rv, 32'h0000_0000);
      rd(12'h100);
      chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
      wr(12'h100, 32'h0000_0000);
      chk({30'h0, br}, {30'h0, `RESP_SLVERR});
      wr(`OFF_BREAK_CONTROL, 32'hFFFF_FFFF);
      chk({30'h0, br}, {30'h0, `RESP_OKAY});
      rd(`OFF_BREAK_CONTROL);
      chk(rv, {16'h0000, `BC_CFG_MASK});
    end
  endtask
  task t_chan;
    begin
      try(16'h1404, 3'h1, 3'h4, 16'h8000, 8'h01, 2'h2);
      try(16'h1404, 3'h2, 3'h4, 16'h4000, 8'h01, 2'h0);
      try(16'h1404, 3'h1, 3'h2, 16'h0080, 8'h01, 2'h3);
      try(16'h1404, 3'h2, 3'h3, 16'h0040, 8'h01, 2'h1);
      try(16'h0404, 3'h1, 3'h4, 16'h8000, 8'h01, 2'h0);
      try(16'h1000, 3'h1, 3'h4, 16'h8000, 8'h01, 2'h0);
      wr(`OFF_BREAK_CONTROL, 32'h0000_D0C0);
      rd(`OFF_BREAK_CONTROL);
      chk(rv, 32'h0000_9000);
    end
  endtask
  task t_ext;
    begin
      bus_cfg_total <= 1'b1;
      try(16'h3000, 3'h4, 3'h4, 16'h4000, 8'h01, 2'h0);
      try(16'h3000, 3'h4, 3'h2, 16'h0040, 8'h01, 2'h1);
      try(16'h1000, 3'h4, 3'h4, 16'h0000, 8'h00, 2'h0);
      bus_cfg_total <= 1'b0;
      try(16'h3000, 3'h4, 3'h4, 16'h0000, 8'h00, 2'h0);
    end
  endtask
  task t_seq;
    begin
      try(16'h1010, 3'h1, 3'h2, 16'h0000, 8'h00, 2'h0);
      try(16'h1010, 3'h1, 3'h4, 16'h8000, 8'h00, 2'h0);
      try(16'h1010, 3'h1, 3'h2, 16'h0080, 8'h01, 2'h1);
      try(16'h1008, 3'h1, 3'h2, 16'h0000, 8'h00, 2'h0);
      try(16'h1008, 3'h1, 3'h3, 16'h0080, 8'h01, 2'h1);
    end
  endtask
  task t_irq;
    begin
      wr(`OFF_IRQ_STATUS, 32'h0000_000F);
      wr(`OFF_IRQ_MASK, 32'h0000_000F);
      try(16'h1000, 3'h2, 3'h2, 16'h0040, 8'h01, 2'h1);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(`OFF_IRQ_STATUS);
      chk(rv, 32'h0000_0008);
      wr(`OFF_IRQ_STATUS, 32'h0000_0008);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(`OFF_IRQ_MASK, 32'h0000_0000);
      try(16'h1000, 3'h1, 3'h4, 16'h8000, 8'h01, 2'h0);
      chk({31'h0, irq}, 32'h0000_0000);
      @(posedge clk);
      manual_rst <= 1'b1;
      @(posedge clk);
      manual_rst <= 1'b0;
      rd(`OFF_BREAK_CONTROL);
      chk(rv, 32'h0000_9000);
    end
  endtask
  initial begin
    bad_count = 0;
    tests_run = 0;
    {sys_rst, manual_rst, bus_cfg_total} = 3'h4;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_chan;
    t_ext;
    t_seq;
    t_irq;
    end_of_test;
  end
endmodule // break_control_tb_top
`default_nettype wire

// file: src/break_channel_eval.v
`timescale 1ns/1ps
`default_nettype none

module break_channel_eval (
  // Observed cycle kind
  input  wire cpu_cyc,
  input  wire dma_cyc,
  input  wire ext_cyc,
  // Configuration
  input  wire ext_break_en,
  input  wire bus_cfg_total,
  input  wire data_check_en,
  input  wire armed,
  // Comparator results
  input  wire addr_hit,
  input  wire data_hit,
  // Results
  output wire cpu_match,
  output wire periph_match
);

  wire data_ok;
  wire qualified;
  wire ext_ok;

  assign data_ok   = ~data_check_en | data_hit;
  assign qualified = addr_hit & data_ok & armed;
  // Released-bus cycles carry no data we can compare
  assign ext_ok    = ext_cyc & ext_break_en & bus_cfg_total & ~data_check_en;

  assign cpu_match    = cpu_cyc & qualified;
  assign periph_match = (dma_cyc | ext_ok) & qualified;

endmodule // break_channel_eval

`default_nettype wire

// file: src/break_control.v
`include "break_ctrl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module break_control (
  // Clock and resets
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        manual_rst,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Observed bus cycle, one per clock at most
  input  wire        cpu_cyc,
  input  wire        dma_cyc,
  input  wire        ext_cyc,
  input  wire        fetch_cyc,
  input  wire        bus_cfg_total,
  // Comparator results
  input  wire        chan_a_addr_hit,
  input  wire        chan_b_addr_hit,
  input  wire        chan_b_data_hit,
  // To interrupt controller
  output wire        break_req,
  output wire        break_after,
  output wire        break_chan_b,
  output wire        irq,
  // Live configuration seen by comparators
  output wire        legacy_mode_select,
  output wire        chained_channel_select
);

  // Control and bus state
  reg  [15:0] break_control_ff;
  reg  [15:0] nxt_break_control;
  reg  [3:0]  irq_status_ff;
  reg  [3:0]  irq_mask_ff;
  reg         chain_armed_ff;
  reg         nxt_chain_armed;
  reg         break_req_ff;
  reg         break_after_ff;
  reg         break_chan_b_ff;

  reg         aw_held_ff;
  reg  [11:0] aw_addr_ff;
  reg         w_held_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         rvalid_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  rresp_ff;

  wire        wr_go;
  wire        rd_go;
  wire [15:0] byte_mask;
  wire        wr_ctrl;
  wire        wr_stat;
  wire        wr_mask;
  wire        wr_hit;

  wire        ext_en;
  wire        legacy;
  wire        chained;
  wire        data_en;
  wire        a_cpu_m;
  wire        a_per_m;
  wire        b_cpu_m;
  wire        b_per_m;
  wire        b_armed;
  wire [3:0]  events;
  wire        any_a;
  wire        any_b;
  wire        raise;

  // Field views
  assign ext_en  = break_control_ff[`BC_EXT_BREAK_EN];
  assign legacy  = ~break_control_ff[`BC_LEGACY_MODE];
  assign chained = break_control_ff[`BC_CHAINED];
  assign data_en = break_control_ff[`BC_CHAN_B_DATA_EN];

  assign legacy_mode_select     = break_control_ff[`BC_LEGACY_MODE];
  assign chained_channel_select = chained;

  // Channel B only looks once channel A has fired when chained
  assign b_armed = ~chained | chain_armed_ff;

  break_channel_eval u_chan_a (
    .cpu_cyc       (cpu_cyc),
    .dma_cyc       (dma_cyc),
    .ext_cyc       (ext_cyc),
    .ext_break_en  (ext_en),
    .bus_cfg_total (bus_cfg_total),
    .data_check_en (1'b0),
    .armed         (1'b1),
    .addr_hit      (chan_a_addr_hit),
    .data_hit      (1'b0),
    .cpu_match     (a_cpu_m),
    .periph_match  (a_per_m)
  );

  break_channel_eval u_chan_b (
    .cpu_cyc       (cpu_cyc),
    .dma_cyc       (dma_cyc),
    .ext_cyc       (ext_cyc),
    .ext_break_en  (ext_en),
    .bus_cfg_total (bus_cfg_total),
    .data_check_en (data_en),
    .armed         (b_armed),
    .addr_hit      (chan_b_addr_hit),
    .data_hit      (chan_b_data_hit),
    .cpu_match     (b_cpu_m),
    .periph_match  (b_per_m)
  );

  assign events[`EV_A_CPU]    = a_cpu_m;
  assign events[`EV_A_PERIPH] = a_per_m;
  assign events[`EV_B_CPU]    = b_cpu_m;
  assign events[`EV_B_PERIPH] = b_per_m;

  assign any_a = a_cpu_m | a_per_m;
  assign any_b = b_cpu_m | b_per_m;
  // Chained: channel A only arms, the break comes from channel B
  assign raise = any_b | (any_a & ~chained);

  // Bus handshakes
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  assign wr_go   = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign rd_go   = s_axi_arvalid & ~rvalid_ff;
  assign wr_ctrl = wr_go & ({aw_addr_ff[11:2], 2'b00} == `OFF_BREAK_CONTROL);
  assign wr_stat = wr_go & ({aw_addr_ff[11:2], 2'b00} == `OFF_IRQ_STATUS);
  assign wr_mask = wr_go & ({aw_addr_ff[11:2], 2'b00} == `OFF_IRQ_MASK);
  assign wr_hit  = wr_ctrl | wr_stat | wr_mask;

  assign byte_mask = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

  // Next control word
  always @* begin
    nxt_break_control = break_control_ff;
    if (wr_ctrl) begin
      // Config fields take the written value, reserved stay zero
      nxt_break_control = (break_control_ff & ~(`BC_CFG_MASK & byte_mask))
                        | (w_data_ff[15:0] & `BC_CFG_MASK & byte_mask);
      // Writing zero to a flag clears it, a one leaves it
      nxt_break_control = nxt_break_control
                        & ~(`BC_FLAG_MASK & byte_mask & ~w_data_ff[15:0]);
    end
    // Set beats a same-cycle clear; hardware never clears
    nxt_break_control[`BC_CHAN_A_CPU_FLAG] =
      nxt_break_control[`BC_CHAN_A_CPU_FLAG] | a_cpu_m;
    nxt_break_control[`BC_CHAN_A_PERIPH_FLAG] =
      nxt_break_control[`BC_CHAN_A_PERIPH_FLAG] | a_per_m;
    nxt_break_control[`BC_CHAN_B_CPU_FLAG] =
      nxt_break_control[`BC_CHAN_B_CPU_FLAG] | b_cpu_m;
    nxt_break_control[`BC_CHAN_B_PERIPH_FLAG] =
      nxt_break_control[`BC_CHAN_B_PERIPH_FLAG] | b_per_m;
  end

  // Chain sequencing
  always @* begin
    nxt_chain_armed = chain_armed_ff;
    if (~chained) begin
      nxt_chain_armed = 1'b0;
    end else if (any_b) begin
      nxt_chain_armed = 1'b0;
    end else if (any_a) begin
      nxt_chain_armed = 1'b1;
    end
  end

  // Control register; manual reset leaves it alone on purpose
  always @(posedge clk) begin
    if (sys_rst) begin
      break_control_ff <= `BC_RESET;
    end else begin
      break_control_ff <= nxt_break_control;
    end
  end

  // Sequencing and break request
  always @(posedge clk) begin
    if (sys_rst | manual_rst) begin
      chain_armed_ff  <= 1'b0;
      break_req_ff    <= 1'b0;
      break_after_ff  <= 1'b0;
      break_chan_b_ff <= 1'b0;
    end else begin
      chain_armed_ff <= nxt_chain_armed;
      break_req_ff   <= raise;
      if (raise) begin
        break_chan_b_ff <= any_b;
        // Legacy mode only knows before-execution breaks
        if (any_b) begin
          break_after_ff <= fetch_cyc & b_cpu_m & ~legacy
                          & break_control_ff[`BC_CHAN_B_AFTER];
        end else begin
          break_after_ff <= fetch_cyc & a_cpu_m & ~legacy
                          & break_control_ff[`BC_CHAN_A_AFTER];
        end
      end
    end
  end

  assign break_req    = break_req_ff;
  assign break_after  = break_after_ff;
  assign break_chan_b = break_chan_b_ff;

  // Sticky interrupt status, one per event
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_stat
      always @(posedge clk) begin
        if (sys_rst) begin
          irq_status_ff[gi] <= 1'b0;
        end else if (events[gi]) begin
          irq_status_ff[gi] <= 1'b1;
        end else if (wr_stat & w_strb_ff[0] & w_data_ff[gi]) begin
          irq_status_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_mask_ff <= `IRQ_RESET;
    end else if (wr_mask & w_strb_ff[0]) begin
      irq_mask_ff <= w_data_ff[3:0];
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // Write address and data capture, either order
  always @(posedge clk) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response
  always @(posedge clk) begin
    if (sys_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read path; unmapped reads answer zero with an error
  always @(posedge clk) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        `OFF_BREAK_CONTROL: begin
          rdata_ff <= {16'h0000, break_control_ff};
        end
        `OFF_IRQ_STATUS: begin
          rdata_ff <= {28'h000_0000, irq_status_ff};
        end
        `OFF_IRQ_MASK: begin
          rdata_ff <= {28'h000_0000, irq_mask_ff};
        end
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // break_control

`default_nettype wire

// file: src/break_ctrl_defs.vh
`ifndef BREAK_CTRL_DEFS_VH
`define BREAK_CTRL_DEFS_VH

// Register byte offsets
`define OFF_BREAK_CONTROL   12'h000
`define OFF_IRQ_STATUS      12'h004
`define OFF_IRQ_MASK        12'h008

// Break control field positions
`define BC_CHAN_A_CPU_FLAG    15
`define BC_CHAN_A_PERIPH_FLAG 14
`define BC_EXT_BREAK_EN       13
`define BC_LEGACY_MODE        12
`define BC_CHAN_A_AFTER       10
`define BC_CHAN_B_CPU_FLAG    7
`define BC_CHAN_B_PERIPH_FLAG 6
`define BC_CHAINED            4
`define BC_CHAN_B_DATA_EN     3
`define BC_CHAN_B_AFTER       2

// Field masks and reset values
`define BC_RESET        16'h0000
`define BC_CFG_MASK     16'h341C
`define BC_FLAG_MASK    16'hC0C0
`define IRQ_RESET       4'h0

// Status and mask bit positions
`define EV_A_CPU        0
`define EV_A_PERIPH     1
`define EV_B_CPU        2
`define EV_B_PERIPH     3

// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif
